// ### rtl/oca_pkg.sv
// Contract
// - Unsupported request: reply unable-to-comply with own address, enter that state.
// - Each byte reply is a data message, opcode flag 0, odd bit as request.
// - Every toggled next-byte returns the next register octet until all delivered.
// - Any other message in read state leads to unable-to-comply state.
// - Toggled next-byte after the last byte is answered with end-of-data.
// - Hold-state or return-to-normal ends a read; register released, back to idle.
// - Each written data byte is acknowledged by echoing the message unchanged.
// - End-of-data ends a write; register released, back to idle.
// - Any other message in write state leads to unable-to-comply state.
// - Data bytes beyond the register end are answered with end-of-data.
// - Indicator is 1 if an anomaly occurred last period, else 0.
// - Corrected octets in a fast or slow block raise its corrected anomaly.
// - Uncorrected errors in a fast or slow block raise its block-error anomaly.
// - All near-end primitives are represented; far-end ones optional here.
// - Each performance count has a settable, readable threshold; crossings reported.
// - In idle every received management message is echoed back, except data bytes and unsupported requests, which get unable-to-comply.
// - A frame with uncorrectable error is answered with the error message.
// - Register bytes are delivered most significant byte first.
package oca_pkg;

  // Message opcodes carried in the information field
  localparam logic [7:0] OP_UTC = 8'h04;
  localparam logic [7:0] OP_EOD = 8'h0E;
  localparam logic [7:0] OP_NEXT = 8'h10;
  localparam logic [7:0] OP_ERR = 8'h14;
  localparam logic [7:0] OP_HOLD = 8'h01;
  localparam logic [7:0] OP_RTN = 8'h02;
  // Upper nibble of read and write opcodes, lower nibble names the register
  localparam logic [3:0] OP_RD_HI = 4'h2;
  localparam logic [3:0] OP_WR_HI = 4'h3;
  // Default own address, arbitrary
  localparam logic [1:0] ADDR_DEF = 2'h1;

  // Near-end anomaly indicator positions
  localparam int IND_FEC_F = 0;
  localparam int IND_FEC_S = 1;
  localparam int IND_BE_F = 2;
  localparam int IND_BE_S = 3;
  localparam int N_IND = 4;
  localparam int THR_W = 16;
  localparam logic [THR_W-1:0] THR_RST = 16'hFFFF;

  // One management message on the link
  typedef struct packed {
    logic [1:0] addr;
    logic op;
    logic odd;
    logic [7:0] info;
  } oca_msg_t;

  // Block check result from the decoder
  typedef struct packed {
    logic done;
    logic corr;
    logic uncorr;
  } oca_blk_t;

  // Protocol states, Gray along idle-read-write
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD = 2'b01,
    ST_WR = 2'b11,
    ST_UTC = 2'b10
  } oca_state_t;

endpackage : oca_pkg

// ### rtl/oca_line_mon.sv
module oca_line_mon #(
  parameter int N = 4,
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Anomaly events and period strobe
  input wire logic [N-1:0] ev_i,
  input wire logic period_i,
  // Threshold access
  input wire logic [N-1:0] thr_we_i,
  input wire logic [TW-1:0] thr_wdata_i,
  // Indicators and reports
  output logic [N-1:0] ind_o,
  output logic [N-1:0][TW-1:0] thr_o,
  output logic [N-1:0] cross_o
);

  if (N < 1 || TW < 2) begin : g_chk
    $error("oca_line_mon: bad parameters");
  end

  // Per indicator: sticky seen flag, period count and threshold
  for (genvar i = 0; i < N; i++) begin : g_ind
    logic seen_q;
    logic [TW-1:0] cnt_q;
    logic [TW-1:0] thr_q;
    logic [TW-1:0] cnt_inc;
    assign cnt_inc = cnt_q + TW'(1);

    // Event in the strobe cycle closes into the ending period, so none is lost
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        seen_q <= 1'b0;
        ind_o[i] <= 1'b0;
      end else if (period_i) begin
        ind_o[i] <= seen_q | ev_i[i];
        seen_q <= 1'b0;
      end else if (ev_i[i]) begin
        seen_q <= 1'b1;
      end
    end

    // Count saturates so a long period cannot wrap below the threshold
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        cnt_q <= '0;
        cross_o[i] <= 1'b0;
      end else begin
        cross_o[i] <= ev_i[i] && !period_i && cnt_inc == thr_q;
        if (period_i) begin
          cnt_q <= '0;
        end else if (ev_i[i] && cnt_q != '1) begin
          cnt_q <= cnt_inc;
        end
      end
    end

    // Threshold set and read back by management
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        thr_q <= TW'(oca_pkg::THR_RST);
      end else if (thr_we_i[i]) begin
        thr_q <= thr_wdata_i;
      end
    end
    assign thr_o[i] = thr_q;

    ind_now_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (period_i && ev_i[i]) |=> ind_o[i])
      else $error("indicator missed an anomaly of the closing period");
  end

endmodule : oca_line_mon

// ### rtl/oca_remote.sv
module oca_remote #(
  parameter logic [1:0] OWN_ADDR = oca_pkg::ADDR_DEF,
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Received messages
  input wire logic rx_valid_i,
  input wire oca_pkg::oca_msg_t rx_msg_i,
  input wire logic rx_crc_err_i,
  // Sent messages
  output logic tx_valid_o,
  output oca_pkg::oca_msg_t tx_msg_o,
  // Register file
  output logic [3:0] reg_sel_o,
  output logic [LEN_W-1:0] reg_idx_o,
  input wire logic [LEN_W-1:0] reg_len_i,
  input wire logic reg_wable_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_busy_o,
  output oca_pkg::oca_state_t state_o,
  // Line monitor
  input wire oca_pkg::oca_blk_t blk_fast_i,
  input wire oca_pkg::oca_blk_t blk_slow_i,
  input wire logic period_i,
  input wire logic [oca_pkg::N_IND-1:0] thr_we_i,
  input wire logic [oca_pkg::THR_W-1:0] thr_wdata_i,
  output logic [oca_pkg::N_IND-1:0] ind_o,
  output logic [oca_pkg::N_IND-1:0][oca_pkg::THR_W-1:0] thr_o,
  output logic [oca_pkg::N_IND-1:0] cross_o
);

  if (LEN_W < 7 || LEN_W > 16) begin : g_chk
    $error("oca_remote: LEN_W must hold the 64-byte register");
  end

  oca_pkg::oca_state_t st_q, st_d;
  logic exp_q, exp_d;
  logic [LEN_W-1:0] idx_q, idx_d;
  logic [3:0] sel_q, sel_d;
  logic send_d, wr_d;
  oca_pkg::oca_msg_t tx_d;

  // Message decode
  wire logic rx_ok = rx_valid_i && !rx_crc_err_i && rx_msg_i.addr == OWN_ADDR;
  wire logic is_op = rx_msg_i.op;
  wire logic is_leave = is_op && (rx_msg_i.info == oca_pkg::OP_HOLD ||
                                  rx_msg_i.info == oca_pkg::OP_RTN);
  wire logic is_rd = is_op && rx_msg_i.info[7:4] == oca_pkg::OP_RD_HI;
  wire logic is_wr = is_op && rx_msg_i.info[7:4] == oca_pkg::OP_WR_HI;
  wire logic is_eod = is_op && rx_msg_i.info == oca_pkg::OP_EOD;
  wire logic nxt_ok = is_op && rx_msg_i.info == oca_pkg::OP_NEXT && rx_msg_i.odd == exp_q;
  wire logic wbyte_ok = !is_op && rx_msg_i.odd == exp_q;
  wire logic more = idx_q < reg_len_i;
  wire logic hit_len = reg_len_i != '0;
  wire logic [LEN_W-1:0] idx_inc = idx_q + LEN_W'(1);

  // Canned replies, all carrying our own address
  wire oca_pkg::oca_msg_t utc_msg = '{OWN_ADDR, 1'b1, 1'b0, oca_pkg::OP_UTC};
  wire oca_pkg::oca_msg_t eod_msg = '{OWN_ADDR, 1'b1, 1'b0, oca_pkg::OP_EOD};
  wire oca_pkg::oca_msg_t err_msg = '{OWN_ADDR, 1'b1, 1'b0, oca_pkg::OP_ERR};
  wire oca_pkg::oca_msg_t dat_msg = '{OWN_ADDR, 1'b0, rx_msg_i.odd, reg_rdata_i};

  // The register lookup follows the request while idle, then stays held
  assign reg_sel_o = (st_q == oca_pkg::ST_IDLE) ? rx_msg_i.info[3:0] : sel_q;
  assign reg_idx_o = idx_q;
  assign reg_busy_o = st_q == oca_pkg::ST_RD || st_q == oca_pkg::ST_WR;
  assign state_o = st_q;

  // Protocol engine: exactly one reply for each accepted message
  always_comb begin
    st_d = st_q;
    exp_d = exp_q;
    idx_d = idx_q;
    sel_d = sel_q;
    send_d = 1'b0;
    wr_d = 1'b0;
    tx_d = rx_msg_i;
    if (rx_valid_i && rx_crc_err_i) begin
      send_d = 1'b1;
      tx_d = err_msg;
    end else if (rx_ok) begin
      send_d = 1'b1;
      case (st_q)
        oca_pkg::ST_IDLE: begin
          if (is_rd && hit_len) begin
            st_d = oca_pkg::ST_RD;
            exp_d = 1'b1;
            idx_d = '0;
            sel_d = rx_msg_i.info[3:0];
          end else if (is_wr && hit_len && reg_wable_i) begin
            st_d = oca_pkg::ST_WR;
            exp_d = 1'b1;
            idx_d = '0;
            sel_d = rx_msg_i.info[3:0];
          end else if (is_rd || is_wr || !is_op) begin
            st_d = oca_pkg::ST_UTC;
            tx_d = utc_msg;
          end
          // Anything else is simply echoed
        end
        oca_pkg::ST_RD: begin
          if (nxt_ok) begin
            exp_d = ~exp_q;
            if (more) begin
              tx_d = dat_msg;
              idx_d = idx_inc;
            end else begin
              tx_d = eod_msg;
            end
          end else if (is_leave) begin
            st_d = oca_pkg::ST_IDLE;
          end else begin
            st_d = oca_pkg::ST_UTC;
            tx_d = utc_msg;
          end
        end
        oca_pkg::ST_WR: begin
          if (wbyte_ok) begin
            exp_d = ~exp_q;
            if (more) begin
              wr_d = 1'b1;
              idx_d = idx_inc;
            end else begin
              tx_d = eod_msg;
            end
          end else if (is_eod) begin
            st_d = oca_pkg::ST_IDLE;
          end else begin
            st_d = oca_pkg::ST_UTC;
            tx_d = utc_msg;
          end
        end
        oca_pkg::ST_UTC: begin
          if (is_leave) begin
            st_d = oca_pkg::ST_IDLE;
          end else begin
            tx_d = utc_msg;
          end
        end
        default: begin
          st_d = oca_pkg::ST_IDLE;
          tx_d = utc_msg;
        end
      endcase
    end
  end

  // Protocol state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= oca_pkg::ST_IDLE;
      exp_q <= 1'b1;
      idx_q <= '0;
      sel_q <= 4'h0;
    end else begin
      st_q <= st_d;
      exp_q <= exp_d;
      idx_q <= idx_d;
      sel_q <= sel_d;
    end
  end

  // Registered reply and write strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_valid_o <= 1'b0;
      tx_msg_o <= '0;
      reg_wr_o <= 1'b0;
      reg_wdata_o <= 8'h00;
    end else begin
      tx_valid_o <= send_d;
      if (send_d) begin
        tx_msg_o <= tx_d;
      end
      reg_wr_o <= wr_d;
      reg_wdata_o <= rx_msg_i.info;
    end
  end

  // Anomaly events, judged once per decoded block
  logic [oca_pkg::N_IND-1:0] ev;
  assign ev[oca_pkg::IND_FEC_F] = blk_fast_i.done && blk_fast_i.corr;
  assign ev[oca_pkg::IND_FEC_S] = blk_slow_i.done && blk_slow_i.corr;
  assign ev[oca_pkg::IND_BE_F] = blk_fast_i.done && blk_fast_i.uncorr;
  assign ev[oca_pkg::IND_BE_S] = blk_slow_i.done && blk_slow_i.uncorr;

  // Near-end indicators; far-end ones are not kept at this end
  oca_line_mon #(
    .N(oca_pkg::N_IND),
    .TW(oca_pkg::THR_W)
  ) u_mon (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ev_i(ev),
    .period_i(period_i),
    .thr_we_i(thr_we_i),
    .thr_wdata_i(thr_wdata_i),
    .ind_o(ind_o),
    .thr_o(thr_o),
    .cross_o(cross_o)
  );

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  utc_entry_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_IDLE && is_rd && !hit_len) |=>
    tx_valid_o && tx_msg_o == utc_msg && st_q == oca_pkg::ST_UTC)
    else $error("unsupported read not refused");

  rd_byte_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_RD && nxt_ok && more) |=>
    tx_valid_o && !tx_msg_o.op && tx_msg_o.odd == $past(rx_msg_i.odd) &&
    tx_msg_o.info == $past(reg_rdata_i) && idx_q == $past(idx_inc))
    else $error("read byte reply wrong");

  rd_eod_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_RD && nxt_ok && !more) |=>
    tx_msg_o.info == oca_pkg::OP_EOD && st_q == oca_pkg::ST_RD)
    else $error("read past end not answered end-of-data");

  rd_bad_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_RD && !nxt_ok && !is_leave) |=>
    st_q == oca_pkg::ST_UTC && tx_msg_o.info == oca_pkg::OP_UTC)
    else $error("bad message in read not refused");

  rd_leave_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_RD && is_leave) |=>
    st_q == oca_pkg::ST_IDLE && !reg_busy_o)
    else $error("read not released");

  wr_echo_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_WR && wbyte_ok && more) |=>
    tx_msg_o == $past(rx_msg_i) && reg_wr_o && reg_wdata_o == $past(rx_msg_i.info))
    else $error("write byte not echoed and stored");

  wr_end_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_WR && is_eod) |=> st_q == oca_pkg::ST_IDLE && !reg_busy_o)
    else $error("write not ended by end-of-data");

  wr_full_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_WR && wbyte_ok && !more) |=>
    !reg_wr_o && tx_msg_o.info == oca_pkg::OP_EOD)
    else $error("overfull write not answered end-of-data");

  wr_bad_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_WR && !wbyte_ok && !is_eod) |=> st_q == oca_pkg::ST_UTC)
    else $error("bad message in write not refused");

  idle_echo_a: assert property (
    (rx_ok && st_q == oca_pkg::ST_IDLE && is_op && !is_rd && !is_wr) |=>
    tx_valid_o && tx_msg_o == $past(rx_msg_i))
    else $error("idle message not echoed");

  err_reply_a: assert property (
    (rx_valid_i && rx_crc_err_i) |=>
    tx_valid_o && tx_msg_o == err_msg && $stable(st_q))
    else $error("damaged frame not answered with error");

  utc_hold_a: assert property (
    (st_q == oca_pkg::ST_UTC && !(rx_ok && is_leave)) |=> st_q == oca_pkg::ST_UTC)
    else $error("unable-to-comply state left early");

  msb_first_a: assert property (
    (st_q == oca_pkg::ST_IDLE ##1 st_q == oca_pkg::ST_RD) |-> idx_q == '0 && exp_q)
    else $error("read does not start at first byte");

endmodule : oca_remote

// ### verification/oca_regfile_model.sv
module oca_regfile_model (
  // Clock
  input wire logic clk_i,
  // Register port of the remote terminal
  input wire logic [3:0] sel_i,
  input wire logic [7:0] idx_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] len_o,
  output logic wable_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [16][4];

  // Seed pattern that the bench can recompute per register and byte
  initial begin
    for (int s = 0; s < 16; s++) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[s][i] = {s[3:0], i[3:0]} ^ 8'hA5;
      end
    end
  end

  // Register 0 has four bytes, 1 and 5 two, all others are absent
  assign len_o = (sel_i == 4'h0) ? 8'h04 : ((sel_i == 4'h1 || sel_i == 4'h5) ? 8'h02 : 8'h00);
  assign wable_o = (sel_i == 4'h5);
  // Past the end the byte keeps changing, so a stale value cannot pass
  assign rdata_o = (idx_i < 8'h04) ? mem_q[sel_i][idx_i[1:0]] : ~idx_i;

  // A write lands on the byte just before the advanced index
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[sel_i][idx_i[1:0] - 2'h1] <= wdata_i;
    end
  end
endmodule : oca_regfile_model

// ### verification/oca_remote_bench.sv
module oca_remote_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic rx_valid_i = 1'b0;
  oca_pkg::oca_msg_t rx_msg_i = '0;
  logic rx_crc_err_i = 1'b0;
  logic tx_valid_o;
  oca_pkg::oca_msg_t tx_msg_o;
  logic [3:0] reg_sel_o;
  logic [7:0] reg_idx_o, reg_len_i, reg_rdata_i, reg_wdata_o;
  logic reg_wable_i, reg_wr_o, reg_busy_o;
  oca_pkg::oca_state_t state_o;
  oca_pkg::oca_blk_t blk_fast_i = '0;
  oca_pkg::oca_blk_t blk_slow_i = '0;
  logic period_i = 1'b0;
  logic [3:0] thr_we_i = 4'h0;
  logic [15:0] thr_wdata_i = 16'h0000;
  logic [3:0] ind_o, cross_o;
  logic [3:0][15:0] thr_o;
  int mismatches = 0;
  int check_count = 0;

  oca_remote u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .rx_valid_i(rx_valid_i),
    .rx_msg_i(rx_msg_i), .rx_crc_err_i(rx_crc_err_i), .tx_valid_o(tx_valid_o),
    .tx_msg_o(tx_msg_o), .reg_sel_o(reg_sel_o), .reg_idx_o(reg_idx_o), .reg_len_i(reg_len_i),
    .reg_wable_i(reg_wable_i), .reg_rdata_i(reg_rdata_i), .reg_wr_o(reg_wr_o),
    .reg_wdata_o(reg_wdata_o), .reg_busy_o(reg_busy_o), .state_o(state_o),
    .blk_fast_i(blk_fast_i), .blk_slow_i(blk_slow_i), .period_i(period_i),
    .thr_we_i(thr_we_i), .thr_wdata_i(thr_wdata_i), .ind_o(ind_o), .thr_o(thr_o),
    .cross_o(cross_o));
  oca_regfile_model u_regs (.clk_i(clk_i), .sel_i(reg_sel_o), .idx_i(reg_idx_o),
    .wr_i(reg_wr_o), .wdata_i(reg_wdata_o), .len_o(reg_len_i), .wable_o(reg_wable_i),
    .rdata_o(reg_rdata_i));

  // 200 MHz core clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  function automatic oca_pkg::oca_msg_t mk(input logic op, input logic odd,
                                           input logic [7:0] info);
    mk = '{oca_pkg::ADDR_DEF, op, odd, info};
  endfunction : mk

  function automatic logic [7:0] rb(input logic [3:0] s, input logic [3:0] i);
    rb = {s, i} ^ 8'hA5;
  endfunction : rb

  // One message in, reply checked in the cycle it stands
  task automatic xact(input oca_pkg::oca_msg_t m, input logic crc, input logic ev,
                      input oca_pkg::oca_msg_t e, input oca_pkg::oca_state_t st);
    logic wr;
    @(negedge clk_i);
    rx_valid_i = 1'b1;
    rx_msg_i = m;
    rx_crc_err_i = crc;
    @(negedge clk_i);
    wr = ev && !e.op && st == oca_pkg::ST_WR;
    check(tx_valid_o, ev);
    if (ev) check({tx_msg_o.addr, tx_msg_o.op, tx_msg_o.info}, {e.addr, e.op, e.info});
    if (ev && !e.op) check(tx_msg_o.odd, e.odd);
    check(state_o, st);
    check(reg_busy_o, st == oca_pkg::ST_RD || st == oca_pkg::ST_WR);
    check(reg_wr_o, wr);
    if (wr) check(reg_wdata_o, e.info);
    rx_valid_i = 1'b0;
    rx_msg_i = ~m;
    rx_crc_err_i = 1'b0;
  endtask : xact

  task automatic echo(input logic [7:0] info, input oca_pkg::oca_state_t st);
    xact(mk(1'b1, 1'b0, info), 1'b0, 1'b1, mk(1'b1, 1'b0, info), st);
  endtask : echo

  task automatic utc(input oca_pkg::oca_msg_t m);
    xact(m, 1'b0, 1'b1, mk(1'b1, 1'b0, oca_pkg::OP_UTC), oca_pkg::ST_UTC);
  endtask : utc

  task automatic rd(input logic odd, input logic [7:0] b);
    xact(mk(1'b1, odd, oca_pkg::OP_NEXT), 1'b0, 1'b1, mk(1'b0, odd, b), oca_pkg::ST_RD);
  endtask : rd

  // Damaged frame: error reply, state kept
  task automatic err(input oca_pkg::oca_msg_t m, input oca_pkg::oca_state_t st);
    xact(m, 1'b1, 1'b1, mk(1'b1, 1'b0, oca_pkg::OP_ERR), st);
  endtask : err

  // Request past the register end: end-of-data reply
  task automatic eod(input oca_pkg::oca_msg_t m, input oca_pkg::oca_state_t st);
    xact(m, 1'b0, 1'b1, mk(1'b1, 1'b0, oca_pkg::OP_EOD), st);
  endtask : eod

  // Decoded block with a corrected or uncorrected result on one channel
  task automatic blk(input int i, input logic ex);
    @(negedge clk_i);
    blk_fast_i = '{1'b1, i == 0, i == 2};
    blk_slow_i = '{1'b1, i == 1, i == 3};
    @(negedge clk_i);
    blk_fast_i = '0;
    blk_slow_i = '0;
    check(cross_o[i], ex);
  endtask : blk

  task automatic per();
    @(negedge clk_i);
    period_i = 1'b1;
    @(negedge clk_i);
    period_i = 1'b0;
  endtask : per

  // Watchdog well beyond the hundred or so cycles the sequence needs
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    check(thr_o[2], 16'hFFFF);
    check(ind_o, 4'h0);
    echo(oca_pkg::OP_HOLD, oca_pkg::ST_IDLE);
    xact('{~oca_pkg::ADDR_DEF, 1'b1, 1'b0, oca_pkg::OP_HOLD}, 1'b0, 1'b0, '0, oca_pkg::ST_IDLE);
    err(mk(1'b1, 1'b0, 8'h77), oca_pkg::ST_IDLE);
    // Full read of a four byte register, then past its end
    echo(8'h20, oca_pkg::ST_RD);
    rd(1'b1, rb(4'h0, 4'h0));
    err(mk(1'b1, 1'b0, oca_pkg::OP_NEXT), oca_pkg::ST_RD);
    rd(1'b0, rb(4'h0, 4'h1));
    rd(1'b1, rb(4'h0, 4'h2));
    rd(1'b0, rb(4'h0, 4'h3));
    eod(mk(1'b1, 1'b1, oca_pkg::OP_NEXT), oca_pkg::ST_RD);
    echo(oca_pkg::OP_RTN, oca_pkg::ST_IDLE);
    // Repeated request without toggling, then leaving the refusal state
    echo(8'h21, oca_pkg::ST_RD);
    rd(1'b1, rb(4'h1, 4'h0));
    utc(mk(1'b1, 1'b1, oca_pkg::OP_NEXT));
    utc(mk(1'b1, 1'b0, oca_pkg::OP_NEXT));
    echo(oca_pkg::OP_HOLD, oca_pkg::ST_IDLE);
    echo(8'h21, oca_pkg::ST_RD);
    echo(oca_pkg::OP_HOLD, oca_pkg::ST_IDLE);
    // Two byte write, one byte too many, then end of data
    echo(8'h35, oca_pkg::ST_WR);
    xact(mk(1'b0, 1'b1, 8'h5A), 1'b0, 1'b1, mk(1'b0, 1'b1, 8'h5A), oca_pkg::ST_WR);
    xact(mk(1'b0, 1'b0, 8'hC3), 1'b0, 1'b1, mk(1'b0, 1'b0, 8'hC3), oca_pkg::ST_WR);
    eod(mk(1'b0, 1'b1, 8'h99), oca_pkg::ST_WR);
    echo(oca_pkg::OP_EOD, oca_pkg::ST_IDLE);
    echo(8'h25, oca_pkg::ST_RD);
    rd(1'b1, 8'h5A);
    rd(1'b0, 8'hC3);
    echo(oca_pkg::OP_RTN, oca_pkg::ST_IDLE);
    // Refusals: next-byte in a write, read-only write, absent register, stray data
    echo(8'h35, oca_pkg::ST_WR);
    utc(mk(1'b1, 1'b1, oca_pkg::OP_NEXT));
    echo(oca_pkg::OP_RTN, oca_pkg::ST_IDLE);
    utc(mk(1'b1, 1'b0, 8'h30));
    echo(oca_pkg::OP_RTN, oca_pkg::ST_IDLE);
    utc(mk(1'b1, 1'b0, 8'h29));
    echo(oca_pkg::OP_HOLD, oca_pkg::ST_IDLE);
    utc(mk(1'b0, 1'b1, 8'h12));
    echo(oca_pkg::OP_RTN, oca_pkg::ST_IDLE);
    // Each anomaly sets only its own indicator, a quiet period clears it
    for (int i = 0; i < 4; i++) begin
      blk(i, 1'b0);
      per();
      check(ind_o, 4'h1 << i);
      per();
      check(ind_o, 4'h0);
    end
    // Threshold of two: second fast corrected block in a period crosses it
    @(negedge clk_i);
    thr_we_i = 4'h1;
    thr_wdata_i = 16'h0002;
    @(negedge clk_i);
    thr_we_i = 4'h0;
    check(thr_o[0], 16'h0002);
    check(thr_o[1], 16'hFFFF);
    blk(0, 1'b0);
    blk(0, 1'b1);
    stop_test();
  end
endmodule : oca_remote_bench
